// *** shared/sledpg_defines.svh ***
// Timing constants for the status LED pattern generator.
// Assumes a 25 MHz system clock; all phase times are in milliseconds.
`ifndef SLEDPG_DEFINES_SVH
`define SLEDPG_DEFINES_SVH
// ==========================================================
// Clock and timebase
// ==========================================================
`define SLEDPG_CLK_HZ 25000000
`define SLEDPG_TICK_US 1000
`define SLEDPG_TICK_CYC ((`SLEDPG_CLK_HZ / 1000000) * `SLEDPG_TICK_US)
// ==========================================================
// Pattern phase times in milliseconds
// ==========================================================
`define SLEDPG_FLASH_MS 200
`define SLEDPG_GAP_MS 200
`define SLEDPG_LONG_MS 1000
`define SLEDPG_FLICK_MS 50
`define SLEDPG_BLINK_MS 200
`endif

// *** shared/sledpg_pkg.sv ***
// Types shared by the status LED pattern generator.
// Assumes nothing beyond a SystemVerilog compiler.
package sledpg_pkg;
    // ======================================================
    // Pattern selection
    // ======================================================
    // Indicator patterns that any LED can show.
    typedef enum logic [2:0] {
        SLEDPG_OFF, SLEDPG_ON, SLEDPG_FLICKER, SLEDPG_BLINK,
        SLEDPG_SINGLE, SLEDPG_DOUBLE, SLEDPG_TRIPLE
    } sledpg_pat_e;

    // Fieldbus slave state machine states.
    typedef enum logic [1:0] {
        SLEDPG_INIT, SLEDPG_PREOP, SLEDPG_SAFEOP, SLEDPG_OP
    } sledpg_bus_e;

    // Fieldbus error conditions, one bit each.
    typedef struct packed {
        logic cfg_err;    // General configuration error.
        logic state_chg;  // Unsolicited state change seen.
        logic wdog_to;    // Application watchdog timeout.
    } sledpg_fberr_s;

    // CANopen conditions, one bit each.
    typedef struct packed {
        logic bus_off;    // Controller is bus off.
        logic sync_err;   // Sync message missing.
        logic ctl_event;  // Guard or heartbeat event.
        logic autobaud;   // Auto baud or LSS in progress.
        logic warn;       // Error counter warning level.
    } sledpg_canerr_s;

    // CANopen network state.
    typedef enum logic [1:0] {
        SLEDPG_CAN_RESET, SLEDPG_CAN_STOPPED, SLEDPG_CAN_PREOP,
        SLEDPG_CAN_OP
    } sledpg_can_e;

    // Per-port link condition.
    typedef struct packed {
        logic link;   // Link pulses received.
        logic act;    // Traffic passing.
    } sledpg_port_s;
endpackage

// *** src/sledpg_top.sv ***
// Status LED pattern generator: maps protocol state to timed LED drive.
// Assumes all state inputs come from logic on CLK_I, except the port
// link and activity lines, which come from pins and are synchronised.
`timescale 1ns/100ps
`include "sledpg_defines.svh"

module sledpg_top
    import sledpg_pkg::*;
(
    // Clock and reset.
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    // Fieldbus state.
    input wire sledpg_bus_e BUS_STATE_I,
    input wire sledpg_fberr_s BUS_ERR_I,
    // Port link conditions, straight from pins.
    input wire sledpg_port_s PORT_IN_I,
    input wire sledpg_port_s PORT_OUT_I,
    // CANopen state.
    input wire sledpg_can_e CAN_STATE_I,
    input wire sledpg_canerr_s CAN_ERR_I,
    // LED drive, high lights the LED.
    output logic BUS_ERR_LED_O,
    output logic BUS_RUN_LED_O,
    output logic LINK_IN_LED_O,
    output logic LINK_OUT_LED_O,
    output logic CAN_RED_LED_O,
    output logic CAN_GREEN_LED_O
);
    // ======================================================
    // Millisecond timebase
    // ======================================================
    localparam int TICK_CYC = `SLEDPG_TICK_CYC;
    localparam int FLASH_MS = `SLEDPG_FLASH_MS;
    localparam int GAP_MS = `SLEDPG_GAP_MS;
    localparam int LONG_MS = `SLEDPG_LONG_MS;
    localparam int FLICK_MS = `SLEDPG_FLICK_MS;
    localparam int BLINK_MS = `SLEDPG_BLINK_MS;
    localparam int NLED = 6;

    logic [14:0] div_reg;  // Cycle divider for the tick.
    logic tick;            // One-cycle pulse each millisecond.

    // Free-running divider; reset restarts it at zero.
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I || div_reg == 15'(TICK_CYC - 1)) begin
            div_reg <= 15'h0000;
        end else begin
            div_reg <= div_reg + 15'h0001;
        end
    end
    assign tick = (div_reg == 15'(TICK_CYC - 1));

    // ======================================================
    // Pin synchronisers for the port link lines
    // ======================================================
    logic [3:0] pin_s1_reg;  // First stage, read only by second.
    logic [3:0] pin_s2_reg;  // Second stage, safe to use.

    // Two flip-flops before any logic reads the pin levels.
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            pin_s1_reg <= 4'h0;
            pin_s2_reg <= 4'h0;
        end else begin
            pin_s1_reg <= {PORT_OUT_I, PORT_IN_I};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // ======================================================
    // Pattern selection per LED
    // ======================================================
    sledpg_pat_e sel [NLED];  // Requested pattern per LED.
    logic can_red_win;        // Red LED is lit this cycle.

    // Map protocol conditions to requested patterns.
    always_comb begin
        // Error LED: off unless a fault is flagged.
        sel[0] = SLEDPG_OFF;
        if (BUS_ERR_I.wdog_to) begin
            sel[0] = SLEDPG_DOUBLE;
        end else if (BUS_ERR_I.state_chg) begin
            sel[0] = SLEDPG_SINGLE;
        end else if (BUS_ERR_I.cfg_err) begin
            sel[0] = SLEDPG_BLINK;
        end
        // Run LED follows the slave state machine.
        case (BUS_STATE_I)
            SLEDPG_INIT: sel[1] = SLEDPG_OFF;
            SLEDPG_PREOP: sel[1] = SLEDPG_BLINK;
            SLEDPG_SAFEOP: sel[1] = SLEDPG_SINGLE;
            SLEDPG_OP: sel[1] = SLEDPG_ON;
            default: sel[1] = SLEDPG_OFF;
        endcase
        // Port LEDs: traffic with link flickers, link alone is steady.
        for (int p = 0; p < 2; p++) begin
            if (pin_s2_reg[2*p] && pin_s2_reg[2*p+1]) begin
                sel[2+p] = SLEDPG_FLICKER;
            end else if (pin_s2_reg[2*p+1]) begin
                sel[2+p] = SLEDPG_ON;
            end else begin
                sel[2+p] = SLEDPG_OFF;
            end
        end
        // CANopen red: highest-numbered condition wins.
        if (CAN_ERR_I.bus_off) begin
            sel[4] = SLEDPG_ON;
        end else if (CAN_ERR_I.sync_err) begin
            sel[4] = SLEDPG_TRIPLE;
        end else if (CAN_ERR_I.ctl_event) begin
            sel[4] = SLEDPG_DOUBLE;
        end else if (CAN_ERR_I.autobaud) begin
            sel[4] = SLEDPG_FLICKER;
        end else if (CAN_ERR_I.warn) begin
            sel[4] = SLEDPG_SINGLE;
        end else begin
            sel[4] = SLEDPG_OFF;
        end
        // CANopen green flickers during auto baud, else shows the network state.
        if (CAN_ERR_I.autobaud) begin
            sel[5] = SLEDPG_FLICKER;
        end else begin
            case (CAN_STATE_I)
                SLEDPG_CAN_STOPPED: sel[5] = SLEDPG_SINGLE;
                SLEDPG_CAN_PREOP: sel[5] = SLEDPG_BLINK;
                SLEDPG_CAN_OP: sel[5] = SLEDPG_ON;
                default: sel[5] = SLEDPG_OFF;
            endcase
        end
    end

    // ======================================================
    // Pattern engines, one per LED
    // ======================================================
    logic [NLED-1:0] lit;  // Lit level per LED.

    // Phase length of step s for pattern p; even steps lit.
    function automatic logic [10:0] step_len(sledpg_pat_e p,
                                             logic [2:0] s);
        logic [10:0] len;
        len = 11'(FLASH_MS);
        case (p)
            SLEDPG_FLICKER: len = 11'(FLICK_MS);
            SLEDPG_BLINK: len = 11'(BLINK_MS);
            SLEDPG_SINGLE: len = (s == 3'h1) ? 11'(LONG_MS)
                : 11'(FLASH_MS);
            SLEDPG_DOUBLE: len = (s == 3'h3) ? 11'(LONG_MS)
                : (s[0] ? 11'(GAP_MS) : 11'(FLASH_MS));
            SLEDPG_TRIPLE: len = (s == 3'h5) ? 11'(LONG_MS)
                : (s[0] ? 11'(GAP_MS) : 11'(FLASH_MS));
            default: len = 11'(FLASH_MS);
        endcase
        return len;
    endfunction

    // Index of the final step of each pattern.
    function automatic logic [2:0] last_step(sledpg_pat_e p);
        logic [2:0] l;
        case (p)
            SLEDPG_DOUBLE: l = 3'h3;
            SLEDPG_TRIPLE: l = 3'h5;
            default: l = 3'h1;
        endcase
        return l;
    endfunction

    genvar g;
    generate
        for (g = 0; g < NLED; g++) begin : gen_led
            sledpg_pat_e pat_reg;   // Pattern now being shown.
            logic [2:0] step_reg;   // Current phase step.
            logic [10:0] ms_reg;    // Milliseconds into the step.
            logic step_end;         // Last millisecond of a step.
            logic cyc_end;          // Last millisecond of a cycle.

            assign step_end = tick &&
                (ms_reg == step_len(pat_reg, step_reg) - 11'h001);
            assign cyc_end = step_end &&
                (step_reg == last_step(pat_reg));

            // Step through phases; take a new pattern only at the end
            // of a cycle, or at once when the current one is steady.
            always_ff @(posedge CLK_I) begin
                if (SYS_RST_I) begin
                    pat_reg <= SLEDPG_OFF;
                    step_reg <= 3'h0;
                    ms_reg <= 11'h000;
                end else if ((pat_reg == SLEDPG_ON ||
                              pat_reg == SLEDPG_OFF) ||
                             cyc_end) begin
                    pat_reg <= sel[g];
                    step_reg <= 3'h0;
                    ms_reg <= 11'h000;
                end else if (step_end) begin
                    step_reg <= step_reg + 3'h1;
                    ms_reg <= 11'h000;
                end else if (tick) begin
                    ms_reg <= ms_reg + 11'h001;
                end
            end

            // Steady patterns ignore the step; others lit on even steps.
            always_comb begin
                case (pat_reg)
                    SLEDPG_ON: lit[g] = 1'b1;
                    SLEDPG_OFF: lit[g] = 1'b0;
                    default: lit[g] = ~step_reg[0];
                endcase
            end
        end
    endgenerate

    // ======================================================
    // Output drive
    // ======================================================
    assign can_red_win = lit[4];

    // Register the LED lines; red overrides green on the bicolour LED.
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            BUS_ERR_LED_O <= 1'b0;
            BUS_RUN_LED_O <= 1'b0;
            LINK_IN_LED_O <= 1'b0;
            LINK_OUT_LED_O <= 1'b0;
            CAN_RED_LED_O <= 1'b0;
            CAN_GREEN_LED_O <= 1'b0;
        end else begin
            BUS_ERR_LED_O <= lit[0];
            BUS_RUN_LED_O <= lit[1];
            LINK_IN_LED_O <= lit[2];
            LINK_OUT_LED_O <= lit[3];
            CAN_RED_LED_O <= lit[4];
            CAN_GREEN_LED_O <= lit[5] && !can_red_win;
        end
    end
endmodule

// *** verif/sledpg_led_watch.sv ***
// Operator model: watches the six LEDs and times how long they stand.
// Assumes LED lines are registered on the system clock.
`timescale 1ns/100ps
module sledpg_led_watch (
    // Clock.
    input wire logic clk_i,
    // LED levels seen by the operator.
    input wire logic [5:0] leds_i,
    // Last view and cycles since it last changed.
    output logic [5:0] seen_o,
    output int hold_o
);
    // A change of any LED restarts the hold count.
    always_ff @(posedge clk_i) begin
        seen_o <= leds_i;
        hold_o <= (leds_i === seen_o) ? hold_o + 1 : 0;
    end
endmodule

// *** verif/sledpg_props.sv ***
// Concurrent checks on the status LED pattern generator's ports.
// Assumes it is bound to sledpg_top and shares its clock and reset.
`timescale 1ns/100ps
module sledpg_props
    import sledpg_pkg::*;
(
    // Clock and reset.
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    // Watched state inputs.
    input wire sledpg_bus_e BUS_STATE_I,
    input wire sledpg_fberr_s BUS_ERR_I,
    input wire sledpg_port_s PORT_IN_I,
    input wire sledpg_port_s PORT_OUT_I,
    input wire sledpg_can_e CAN_STATE_I,
    input wire sledpg_canerr_s CAN_ERR_I,
    // Watched LED drive.
    input wire logic BUS_ERR_LED_O,
    input wire logic BUS_RUN_LED_O,
    input wire logic LINK_IN_LED_O,
    input wire logic LINK_OUT_LED_O,
    input wire logic CAN_RED_LED_O,
    input wire logic CAN_GREEN_LED_O
);
    // ==========================================================
    // Assertions
    // ==========================================================
    // All six LED lines as one vector.
    logic [5:0] leds;
    assign leds = {BUS_ERR_LED_O, BUS_RUN_LED_O, LINK_IN_LED_O,
                   LINK_OUT_LED_O, CAN_RED_LED_O, CAN_GREEN_LED_O};
    // Every check samples on the system clock.
    default clocking cb @(posedge CLK_I); endclocking
    AST_RST_DARK: assert property (SYS_RST_I |=> leds == 6'h00)
        else $error("LED lit after a reset edge.");
    AST_REL_DARK: assert property ($fell(SYS_RST_I) |-> leds == 6'h00)
        else $error("LED lit at reset release.");
    AST_RUN_DARK: assert property (SYS_RST_I ##1
        (!SYS_RST_I && BUS_STATE_I == SLEDPG_INIT)[*4] |-> !BUS_RUN_LED_O)
        else $error("Run LED lit in the first bus state.");
    AST_RUN_LIT: assert property (SYS_RST_I ##1
        (!SYS_RST_I && BUS_STATE_I != SLEDPG_INIT)[*4] |-> BUS_RUN_LED_O)
        else $error("Run LED not lit at pattern start.");
    AST_ERR_DARK: assert property (SYS_RST_I ##1
        (!SYS_RST_I && BUS_ERR_I == 3'h0)[*4] |-> !BUS_ERR_LED_O)
        else $error("Error LED lit without error.");
    AST_ERR_LIT: assert property (SYS_RST_I ##1
        (!SYS_RST_I && BUS_ERR_I != 3'h0)[*4] |-> BUS_ERR_LED_O)
        else $error("Error LED not lit at pattern start.");
    AST_LINK_LIT: assert property (SYS_RST_I ##1
        (!SYS_RST_I && PORT_IN_I.link)[*6] |-> LINK_IN_LED_O)
        else $error("In-port LED dark with link.");
    AST_LINK_DARK: assert property (SYS_RST_I ##1
        (!SYS_RST_I && !PORT_OUT_I.link)[*6] |-> !LINK_OUT_LED_O)
        else $error("Out-port LED lit without link.");
    AST_RED_LIT: assert property (SYS_RST_I ##1
        (!SYS_RST_I && CAN_ERR_I != 5'h00)[*4] |-> CAN_RED_LED_O)
        else $error("Red LED not lit with a bus fault.");
    AST_GREEN_OP: assert property (SYS_RST_I ##1 (!SYS_RST_I &&
        CAN_ERR_I == 5'h00 && CAN_STATE_I == SLEDPG_CAN_OP)[*4]
        |-> CAN_GREEN_LED_O)
        else $error("Green LED dark in operational state.");
    AST_RED_GREEN: assert property (disable iff (SYS_RST_I)
        CAN_RED_LED_O |-> !CAN_GREEN_LED_O)
        else $error("Red and green lit together.");
endmodule

// *** verif/sledpg_top_tb_top.sv ***
// Self-checking bench for the status LED pattern generator.
// Assumes 25 MHz clock; long phases are checked only at their start.
`timescale 1ns/100ps
module sledpg_top_tb_top;
    import sledpg_pkg::*;
    // ==========================================================
    // Signals
    // ==========================================================
    logic clk = 1'b0;
    logic rst = 1'b1;
    sledpg_bus_e bs = SLEDPG_INIT;
    sledpg_fberr_s be = 3'h0;
    sledpg_port_s pi = 2'h0;
    sledpg_port_s po = 2'h0;
    sledpg_can_e cs = SLEDPG_CAN_RESET;
    sledpg_canerr_s ce = 5'h00;
    logic e_o, r_o, i_o, o_o, red_o, grn_o;
    logic [5:0] leds;
    int hold;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    assign leds = {e_o, r_o, i_o, o_o, red_o, grn_o};
    always #20 clk = ~clk;
    sledpg_top dut_u (.CLK_I(clk), .SYS_RST_I(rst), .BUS_STATE_I(bs),
        .BUS_ERR_I(be), .PORT_IN_I(pi), .PORT_OUT_I(po), .CAN_STATE_I(cs),
        .CAN_ERR_I(ce), .BUS_ERR_LED_O(e_o), .BUS_RUN_LED_O(r_o),
        .LINK_IN_LED_O(i_o), .LINK_OUT_LED_O(o_o), .CAN_RED_LED_O(red_o),
        .CAN_GREEN_LED_O(grn_o));
    sledpg_led_watch watch_u (.clk_i(clk), .leds_i(leds), .seen_o(),
        .hold_o(hold));
    // ==========================================================
    // Tasks
    // ==========================================================
    // Prints the verdict and ends the run.
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d.", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Waits n edges, then steps past the edge.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Compares the LED vector.
    task automatic check_leds(input logic [5:0] exp);
        checks_done++;
        if (leds !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, leds);
        end
    endtask
    // Compares a duration against a floor.
    task automatic check_min(input int floor, input int got);
        checks_done++;
        if (got < floor) begin
            mismatches++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, floor, got);
        end
    endtask
    // Sets every state input at once.
    task automatic apply(input logic [1:0] b, input logic [2:0] e,
        input logic [1:0] pin, pout, c, input logic [4:0] f);
        bs = sledpg_bus_e'(b);
        be = e;
        pi = pin;
        po = pout;
        cs = sledpg_can_e'(c);
        ce = f;
    endtask
    // Resets for 6 cycles with inputs set, then releases.
    task automatic start(input logic [1:0] b, input logic [2:0] e,
        input logic [1:0] pin, pout, c, input logic [4:0] f);
        rst = 1'b1;
        apply(b, e, pin, pout, c, f);
        tick(6);
        check_leds(6'h00);
        rst = 1'b0;
        tick(6);
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    // Idle state: every LED dark.
    task automatic sc_idle();
        start(2'h0, 3'h0, 2'h0, 2'h1, 2'h0, 5'h00);
        check_leds(6'h00);
    endtask
    // Steady on, then steady off at once; flicker keeps its cycle.
    task automatic sc_live();
        start(2'h3, 3'h0, 2'h2, 2'h3, 2'h3, 5'h00);
        check_leds(6'h1D);
        apply(2'h0, 3'h0, 2'h0, 2'h0, 2'h3, 5'h00);
        tick(6);
        check_leds(6'h05);
    endtask
    // Faults together: blink, red steady wins, green forced off.
    task automatic sc_faults();
        start(2'h1, 3'h4, 2'h1, 2'h2, 2'h3, 5'h18);
        check_leds(6'h36);
    endtask
    // Flash patterns hold their lit phase after the cause goes away.
    task automatic sc_flash_hold();
        start(2'h2, 3'h3, 2'h3, 2'h3, 2'h1, 5'h01);
        check_leds(6'h3E);
        apply(2'h0, 3'h0, 2'h0, 2'h0, 2'h0, 5'h00);
        tick(1000);
        check_leds(6'h3E);
        check_min(1000, hold);
    endtask
    // Each bus fault alone lights red; each live state lights green.
    task automatic sc_can();
        for (int i = 0; i < 5; i++) begin
            start(2'h0, 3'h0, 2'h0, 2'h0, 2'h3, 5'h01 << i);
            check_leds(6'h02);
        end
        for (int s = 1; s < 4; s++) begin
            start(2'h0, 3'h0, 2'h0, 2'h0, 2'(s), 5'h00);
            check_leds(6'h01);
        end
    endtask
    // ==========================================================
    // Main sequence and hang guard
    // ==========================================================
    initial begin
        sc_idle();
        sc_live();
        sc_faults();
        sc_flash_hold();
        sc_can();
        finish_test();
    end
    // Cuts a hang short well past the expected run length.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            finish_test();
        end
    end
endmodule
bind sledpg_top sledpg_props props_u (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
    .BUS_STATE_I(BUS_STATE_I), .BUS_ERR_I(BUS_ERR_I), .PORT_IN_I(PORT_IN_I),
    .PORT_OUT_I(PORT_OUT_I), .CAN_STATE_I(CAN_STATE_I),
    .CAN_ERR_I(CAN_ERR_I), .BUS_ERR_LED_O(BUS_ERR_LED_O),
    .BUS_RUN_LED_O(BUS_RUN_LED_O), .LINK_IN_LED_O(LINK_IN_LED_O),
    .LINK_OUT_LED_O(LINK_OUT_LED_O), .CAN_RED_LED_O(CAN_RED_LED_O),
    .CAN_GREEN_LED_O(CAN_GREEN_LED_O));
